// ===== rsb_consts.svh
// constants of the receive segmented user bus: sizes and reset values
// assumes inclusion by the package and the design modules only
`ifndef RSB_CONSTS_SVH
`define RSB_CONSTS_SVH

`define RSB_SEGS          4
`define RSB_WORD_W        128
`define RSB_EMPTY_W       4
`define RSB_EMPTY_LOW_W   3
`define RSB_FIFO_DEPTH    8
`define RSB_SLOT_W        2
`define RSB_SLOT_LAST     2'h3
`define RSB_SLOT_RST      2'h0

`endif

// ===== rsb_pkg.sv
// types shared by the receive segmented user bus modules
// assumes rsb_consts.svh is on the include path
`default_nettype none
`include "rsb_consts.svh"

package rsb_pkg;
    typedef logic [`RSB_WORD_W-1:0]                 rsb_word_t;
    typedef logic [`RSB_EMPTY_W-1:0]                rsb_empty_t;
    typedef logic [`RSB_SLOT_W-1:0]                 rsb_slot_t;
    typedef logic [`RSB_SEGS-1:0]                   rsb_segmask_t;
    typedef logic [`RSB_SEGS-1:0][`RSB_WORD_W-1:0]  rsb_segword_t;
    typedef logic [`RSB_SEGS-1:0][`RSB_EMPTY_W-1:0] rsb_segempty_t;
endpackage : rsb_pkg

`default_nettype wire

// ===== rsb_fifo.sv
// small first-in first-out buffer with a registered read stage
// assumes one clock, asynchronous active-low reset, valid/ready on both sides
`default_nettype none
`include "rsb_consts.svh"

module rsb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `RSB_FIFO_DEPTH
) (
    input  wire logic             clock_i,   // core clock
    input  wire logic             rst_n_i,   // async reset, active low
    input  wire logic             wr_valid_i, // word offered
    output logic                  wr_ready_o, // room in storage
    input  wire logic [WIDTH-1:0] wr_data_i, // word to store
    output logic                  rd_valid_o, // read stage holds a word
    input  wire logic             rd_ready_i, // drain takes the word
    output logic      [WIDTH-1:0] rd_data_o  // registered read word
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [CW-1:0]    cnt_q, cnt_d;
    logic             room_q, room_d;
    logic             rv_q, rv_d;
    logic [WIDTH-1:0] rd_q, rd_d;
    logic             push, move;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        push     = wr_valid_i && room_q;
        move     = (cnt_q != '0) && (!rv_q || rd_ready_i);
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        cnt_d    = cnt_q;
        rv_d     = rv_q;
        rd_d     = rd_q;
        if (rv_q && rd_ready_i) begin
            rv_d = 1'b0;
        end
        if (push) begin
            wr_ptr_d = (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
        end
        if (move) begin
            rd_d     = mem_q[rd_ptr_q];
            rv_d     = 1'b1;
            rd_ptr_d = (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
        end
        cnt_d  = cnt_q + CW'(push) - CW'(move);
        room_d = (cnt_d != CW'(DEPTH));
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
            // closed in reset and the first cycle after it, so ready is a plain flop
            room_q   <= 1'b0;
            rv_q     <= 1'b0;
            rd_q     <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            cnt_q    <= cnt_d;
            room_q   <= room_d;
            rv_q     <= rv_d;
            rd_q     <= rd_d;
        end
    end

    // storage needs no reset; it is only read once written
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= wr_data_i;
        end
    end

    assign wr_ready_o = room_q;
    assign rd_valid_o = rv_q;
    assign rd_data_o  = rd_q;
endmodule : rsb_fifo

`default_nettype wire

// ===== rsb_rx_segment_bus.sv
// receive side of the segmented user bus: packs words into four segments
// assumes one word per cycle from the receive path, first/last marked
//
// Summary of operation
// R01: packet data leaves on four segments numbered 0 to 3, each a 128-bit word per cycle.
// R02: a segment word counts only in cycles where that segment's valid is 1.
// R03: a segment's valid qualifies its first, last, bad and empty-count outputs.
// R04: first is 1 on a valid segment that carries the first word of a packet.
// R05: last is 1 on a valid segment that carries the final word of a packet.
// R06: each segment has its own valid; the valid segments in a cycle are a run starting at segment 0.
// R07: bad, when 1 on a valid last segment, marks the ending packet as erroneous.
// R08: a 4-bit empty-byte count per segment is given for the final transfer of a packet.
// R09: with bad and valid both 1, the low three bits of the empty count are zero.
// R10: within a cycle words fill segments from zero upward in consecutive order.
`default_nettype none
`include "rsb_consts.svh"

module rsb_rx_segment_bus #(
    parameter int SEGS  = `RSB_SEGS,
    parameter int DEPTH = `RSB_FIFO_DEPTH
) (
    input  wire logic                    clock_i,                // core clock, 125 MHz
    input  wire logic                    rst_n_i,                // async reset, active low
    input  wire logic                    in_valid_i,             // receive word offered
    output logic                         in_ready_o,             // buffer has room
    input  wire rsb_pkg::rsb_word_t      in_word_i,              // received word
    input  wire logic                    in_first_i,             // word opens a packet
    input  wire logic                    in_last_i,              // word closes a packet
    input  wire logic                    in_bad_i,               // packet in error
    input  wire rsb_pkg::rsb_empty_t     in_empty_bytes_i,       // empty bytes of last word
    input  wire logic                    drain_enable_i,         // 0 stalls the output side
    output rsb_pkg::rsb_segmask_t        rx_segment_valid_o,     // per-segment valid
    output rsb_pkg::rsb_segword_t        rx_segment_word_o,      // per-segment data
    output rsb_pkg::rsb_segmask_t        rx_segment_first_o,     // per-segment start
    output rsb_pkg::rsb_segmask_t        rx_segment_last_o,      // per-segment end
    output rsb_pkg::rsb_segmask_t        rx_segment_bad_o,       // per-segment error
    output rsb_pkg::rsb_segempty_t       rx_segment_empty_bytes_o // per-segment empty count
);
    import rsb_pkg::*;

    localparam int EW = `RSB_EMPTY_W;
    localparam int LW = `RSB_EMPTY_LOW_W;
    localparam int FW = `RSB_WORD_W + 3 + EW;

    // ----------------------------------------------------------------
    // input buffer
    // ----------------------------------------------------------------
    logic          f_valid;
    logic          f_ready;
    logic [FW-1:0] f_data;
    logic [FW-1:0] in_pack;
    logic          ready_raw;

    assign in_pack = {in_word_i, in_first_i, in_last_i, in_bad_i, in_empty_bytes_i};

    rsb_fifo #(
        .WIDTH (FW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n_i),
        .wr_valid_i (in_valid_i),
        .wr_ready_o (ready_raw),
        .wr_data_i  (in_pack),
        .rd_valid_o (f_valid),
        .rd_ready_i (f_ready),
        .rd_data_o  (f_data)
    );

    // fifo ready is itself a flop and also gates the push, so the two never disagree
    assign in_ready_o = ready_raw;

    // ----------------------------------------------------------------
    // unpack popped word
    // ----------------------------------------------------------------
    rsb_word_t  p_word;
    logic       p_first;
    logic       p_last;
    logic       p_bad;
    rsb_empty_t p_empty;
    logic       pop;

    assign {p_word, p_first, p_last, p_bad, p_empty} = f_data;
    assign f_ready = drain_enable_i;
    assign pop     = f_valid && drain_enable_i;

    // ----------------------------------------------------------------
    // segment packer
    // ----------------------------------------------------------------
    rsb_segword_t  acc_word_q, acc_word_d;
    rsb_segmask_t  acc_first_q, acc_first_d;
    rsb_segmask_t  acc_last_q, acc_last_d;
    rsb_segmask_t  acc_bad_q, acc_bad_d;
    rsb_segempty_t acc_empty_q, acc_empty_d;
    rsb_slot_t     slot_q, slot_d;

    rsb_segmask_t  valid_q, valid_d;
    rsb_segword_t  word_q, word_d;
    rsb_segmask_t  first_q, first_d;
    rsb_segmask_t  last_q, last_d;
    rsb_segmask_t  bad_q, bad_d;
    rsb_segempty_t empty_q, empty_d;

    // a word is held until its cycle is complete: four slots filled or the
    // packet ended; a partial packet waits for more input with no timeout
    always_comb begin
        acc_word_d  = acc_word_q;
        acc_first_d = acc_first_q;
        acc_last_d  = acc_last_q;
        acc_bad_d   = acc_bad_q;
        acc_empty_d = acc_empty_q;
        slot_d      = slot_q;
        valid_d     = '0;
        word_d      = word_q;
        first_d     = '0;
        last_d      = '0;
        bad_d       = '0;
        empty_d     = '0;
        if (pop) begin
            acc_word_d[slot_q]  = p_word;                  // R01
            acc_first_d[slot_q] = p_first;
            acc_last_d[slot_q]  = p_last;
            acc_bad_d[slot_q]   = p_bad && p_last;
            acc_empty_d[slot_q] = p_empty;
            if (p_last || slot_q == `RSB_SLOT_LAST) begin
                for (int i = 0; i < SEGS; i++) begin
                    if (i <= int'(slot_q)) begin
                        valid_d[i] = 1'b1;                 // R06 R10
                        word_d[i]  = acc_word_d[i];        // R02
                        first_d[i] = acc_first_d[i];       // R03 R04
                        last_d[i]  = acc_last_d[i];        // R05
                        bad_d[i]   = acc_bad_d[i];         // R07
                        if (acc_last_d[i]) begin
                            empty_d[i] = acc_empty_d[i];   // R08
                            if (acc_bad_d[i]) begin
                                empty_d[i][LW-1:0] = '0;   // R09
                            end
                        end
                    end
                end
                slot_d = `RSB_SLOT_RST;                    // R10
            end else begin
                slot_d = slot_q + 1'b1;                    // R10
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_word_q  <= '0;
            acc_first_q <= '0;
            acc_last_q  <= '0;
            acc_bad_q   <= '0;
            acc_empty_q <= '0;
            slot_q      <= `RSB_SLOT_RST;
            valid_q     <= '0;
            word_q      <= '0;
            first_q     <= '0;
            last_q      <= '0;
            bad_q       <= '0;
            empty_q     <= '0;
        end else begin
            acc_word_q  <= acc_word_d;
            acc_first_q <= acc_first_d;
            acc_last_q  <= acc_last_d;
            acc_bad_q   <= acc_bad_d;
            acc_empty_q <= acc_empty_d;
            slot_q      <= slot_d;
            valid_q     <= valid_d;
            word_q      <= word_d;
            first_q     <= first_d;
            last_q      <= last_d;
            bad_q       <= bad_d;
            empty_q     <= empty_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign rx_segment_valid_o       = valid_q;
    assign rx_segment_word_o        = word_q;
    assign rx_segment_first_o       = first_q;
    assign rx_segment_last_o        = last_q;
    assign rx_segment_bad_o         = bad_q;
    assign rx_segment_empty_bytes_o = empty_q;
endmodule : rsb_rx_segment_bus

`default_nettype wire

// ===== rsb_rx_segment_bus_asserts.sv
// checker on the segment outputs of the receive segmented user bus
// assumes it is bound onto rsb_rx_segment_bus, one clock domain
`default_nettype none

module rsb_rx_segment_bus_asserts (
    input wire logic                  clock_i,                 // core clock
    input wire logic                  rst_n_i,                 // async reset, active low
    input wire logic                  drain_enable_i,          // output side stall
    input wire rsb_pkg::rsb_segmask_t  rx_segment_valid_o,      // per-segment valid
    input wire rsb_pkg::rsb_segmask_t  rx_segment_first_o,      // per-segment start
    input wire rsb_pkg::rsb_segmask_t  rx_segment_last_o,       // per-segment end
    input wire rsb_pkg::rsb_segmask_t  rx_segment_bad_o,        // per-segment error
    input wire rsb_pkg::rsb_segempty_t rx_segment_empty_bytes_o // per-segment empty count
);
    timeunit 1ns;
    timeprecision 1ps;
    import rsb_pkg::*;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // k picks the check: 0 forced low bits, 1 count only on last, 2 nothing after last
    function automatic logic seg_ok(input int k, input rsb_segmask_t v, l, b,
                                    input rsb_segempty_t e);
        logic ok = 1'b1;
        for (int s = 0; s < 4; s++) begin
            if (k == 0 && b[s] && v[s] && e[s][2:0] != 3'h0) ok = 1'b0;
            if (k == 1 && e[s] != 4'h0 && !(v[s] && l[s])) ok = 1'b0;
            if (k == 2 && s < 3 && v[s] && l[s] && v[(s + 1) % 4]) ok = 1'b0;
        end
        return ok;
    endfunction : seg_ok

    sequence s_stalled;
        !drain_enable_i [*3];
    endsequence

    a_first_qualified: assert property ((rx_segment_first_o & ~rx_segment_valid_o) == 4'h0)
        else $error("first without valid");
    a_last_qualified: assert property ((rx_segment_last_o & ~rx_segment_valid_o) == 4'h0)
        else $error("last without valid");
    a_bad_on_last: assert property (
        (rx_segment_bad_o & ~(rx_segment_valid_o & rx_segment_last_o)) == 4'h0)
        else $error("bad outside a valid last segment");
    a_empty_low_zero: assert property (seg_ok(0, rx_segment_valid_o, rx_segment_last_o,
        rx_segment_bad_o, rx_segment_empty_bytes_o)) else $error("empty low bits set with bad");
    a_empty_on_last: assert property (seg_ok(1, rx_segment_valid_o, rx_segment_last_o,
        rx_segment_bad_o, rx_segment_empty_bytes_o)) else $error("empty count off last");
    a_nothing_after_last: assert property (seg_ok(2, rx_segment_valid_o, rx_segment_last_o,
        rx_segment_bad_o, rx_segment_empty_bytes_o)) else $error("segment valid after last");
    a_valid_packed: assert property (
        rx_segment_valid_o inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
        else $error("valid segments not contiguous from zero");
    a_first_seg_zero: assert property (rx_segment_first_o[3:1] == 3'h0)
        else $error("packet start off segment zero");
    a_stall_quiet: assert property (s_stalled |-> rx_segment_valid_o == 4'h0)
        else $error("segments emitted while stalled");
    c_stalled: cover property (s_stalled);
endmodule : rsb_rx_segment_bus_asserts

bind rsb_rx_segment_bus rsb_rx_segment_bus_asserts rsb_rx_segment_bus_asserts_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .drain_enable_i(drain_enable_i),
    .rx_segment_valid_o(rx_segment_valid_o), .rx_segment_first_o(rx_segment_first_o),
    .rx_segment_last_o(rx_segment_last_o), .rx_segment_bad_o(rx_segment_bad_o),
    .rx_segment_empty_bytes_o(rx_segment_empty_bytes_o));

`default_nettype wire

// ===== rsb_sink_model.sv
// downstream consumer of the segments: stalls on a fixed pattern, counts words
// assumes drain_enable_o feeds the design's stall input
`default_nettype none

module rsb_sink_model (
    input  wire logic                 clock_i,        // core clock
    input  wire logic                 rst_n_i,        // async reset, active low
    input  wire logic                 slow_i,         // 1 stalls twelve cycles of sixteen
    input  wire rsb_pkg::rsb_segmask_t valid_i,        // segment valids seen
    output logic                      drain_enable_o, // stall control
    output int unsigned               words_o         // valid segments taken
);
    timeunit 1ns;
    timeprecision 1ps;
    import rsb_pkg::*;
    logic [3:0] phase_q;

    // changes on the falling edge so the design samples a settled level
    always @(negedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_q <= 4'h0;
            words_o <= 0;
        end else begin
            phase_q <= phase_q + 4'h1;
            words_o <= words_o + $countones(valid_i);
        end
    end
    assign drain_enable_o = !slow_i || phase_q[3:2] == 2'h3;
endmodule : rsb_sink_model

`default_nettype wire

// ===== rsb_rx_segment_bus_tb_top.sv
// self-checking bench: random packets in, segments compared with a queue model
// assumes the design, checker and sink model are compiled before it
`default_nettype none

module rsb_rx_segment_bus_tb_top import rsb_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic          clock_i, rst_n_i, in_valid_i, in_ready_o, in_first_i, in_last_i, in_bad_i;
    logic          drain, slow;
    rsb_word_t     in_word_i;
    rsb_empty_t    in_empty;
    rsb_segmask_t  sv, sf, sl, sb;
    rsb_segword_t  sw;
    rsb_segempty_t se;
    int            err_total, num_checks, pushed, refused;
    int unsigned   words_seen;
    logic [31:0]   seed = 32'h2df7698a;
    rsb_word_t     exp_w[$];
    logic [6:0]    exp_m[$];

    rsb_rx_segment_bus rsb_rx_segment_bus_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .in_valid_i(in_valid_i), .in_ready_o(in_ready_o), .in_word_i(in_word_i),
        .in_first_i(in_first_i), .in_last_i(in_last_i), .in_bad_i(in_bad_i),
        .in_empty_bytes_i(in_empty), .drain_enable_i(drain), .rx_segment_valid_o(sv),
        .rx_segment_word_o(sw), .rx_segment_first_o(sf), .rx_segment_last_o(sl),
        .rx_segment_bad_o(sb), .rx_segment_empty_bytes_o(se));
    rsb_sink_model rsb_sink_model_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .slow_i(slow),
        .valid_i(sv), .drain_enable_o(drain), .words_o(words_seen));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic check(input string what, input logic [127:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop

    // bad is also raised on inner words at random: only a last word may carry it
    task automatic send_pkt(input int n, input logic all_bad);
        logic [31:0] r;
        logic        last;
        for (int i = 0; i < n; i++) begin
            r = xs();
            last = (i == n - 1);
            in_valid_i = 1'b1;
            in_word_i = {xs(), xs(), xs(), r};
            in_first_i = (i == 0);
            in_last_i = last;
            in_bad_i = all_bad | r[4];
            in_empty = r[3:0];
            while (in_ready_o !== 1'b1) begin
                refused++;
                @(negedge clock_i);
            end
            exp_w.push_back(in_word_i);
            exp_m.push_back({i == 0, last, in_bad_i & last,
                !last ? 4'h0 : in_bad_i ? {r[3], 3'h0} : r[3:0]});
            pushed++;
            @(negedge clock_i);
        end
    endtask : send_pkt

    task automatic run_test(input string name, input logic slow_mode, input int npk,
                            input logic all_bad);
        int lim = 0;
        slow = slow_mode;
        refused = 0;
        for (int k = 0; k < npk; k++) send_pkt(1 + int'(xs() % 9), all_bad);
        // valid drops only once per test, so no zero-time low pulse between packets
        in_valid_i = 1'b0;
        while (exp_w.size() != 0 && lim < 800) begin
            lim++;
            @(negedge clock_i);
        end
        check("words left over", 0, exp_w.size());
        if (slow_mode) check("refusal under stall", 1, refused > 0);
        $display("test %s done, %0d refused cycles", name, refused);
    endtask : run_test

    // ----------------------------------------
    // model comparison at every emitted segment
    // ----------------------------------------
    always @(negedge clock_i) begin
        if (rst_n_i) for (int s = 0; s < 4; s++) if (sv[s] === 1'b1) begin
            if (exp_w.size() == 0) check("segment without packet", 0, 1);
            else begin
                check("segment word", exp_w.pop_front(), sw[s]);
                check("segment marks", exp_m.pop_front(), {sf[s], sl[s], sb[s], se[s]});
            end
        end
    end

    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    initial begin
        #(20000 * 8);
        err_total++;
        report_and_stop();
    end

    initial begin
        {rst_n_i, in_valid_i, in_first_i, in_last_i, in_bad_i, slow} = 6'h0;
        in_word_i = '0;
        in_empty = 4'h0;
        repeat (8) @(negedge clock_i);
        rst_n_i = 1'b1;
        repeat (2) @(negedge clock_i);
        run_test("fast drain", 1'b0, 30, 1'b0);
        run_test("stalled drain", 1'b1, 30, 1'b0);
        run_test("bad packets", 1'b0, 12, 1'b1);
        // the sink counts by non-blocking update: let its last count settle
        @(negedge clock_i);
        check("words at sink", pushed, words_seen);
        rst_n_i = 1'b0;
        @(negedge clock_i);
        check("valid in reset", 0, {sv, in_ready_o});
        rst_n_i = 1'b1;
        repeat (2) @(negedge clock_i);
        run_test("after reset", 1'b1, 10, 1'b0);
        report_and_stop();
    end
endmodule : rsb_rx_segment_bus_tb_top

`default_nettype wire
